/* common/rss_params.svh */
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

// Timing
`define RSS_CLK_PERIOD_NS 5
`define RSS_DELAY_NS 2000000

// Own register word indices (byte address = index * 4)
`define RSS_IDX_STATUS 10'h001
`define RSS_IDX_MASK 10'h002
`define RSS_IDX_STATE 10'h003
`define RSS_IDX_LOCK 10'h004
`define RSS_IDX_SFR_BASE 10'h080
`define RSS_IDX_SFR_END 10'h0ff

// Event bit positions in status and mask
`define RSS_EV_COLD 0
`define RSS_EV_DIP 1
`define RSS_EV_PIN 2
`define RSS_EV_REJECT 3
`define RSS_EV_RUN 4
`define RSS_EV_W 5

// Lock command bits
`define RSS_LOCK_B1 0
`define RSS_LOCK_B2 1
`define RSS_LOCK_ERASE 7

// Special register addresses
`define RSS_SFR_SP 8'h81
`define RSS_SFR_DPL 8'h82
`define RSS_SFR_DPH 8'h83
`define RSS_SFR_POWER_CONTROL 8'h87
`define RSS_SFR_TIMER_CONTROL 8'h88
`define RSS_SFR_TIMER_MODES 8'h89
`define RSS_SFR_TL0 8'h8a
`define RSS_SFR_TL1 8'h8b
`define RSS_SFR_TH0 8'h8c
`define RSS_SFR_TH1 8'h8d
`define RSS_SFR_CLK 8'h8f
`define RSS_SFR_P1 8'h90
`define RSS_SFR_COMPARATOR_CTRL_STATUS 8'h97
`define RSS_SFR_SERIAL_CONTROL 8'h98
`define RSS_SFR_SERIAL_BUFFER 8'h99
`define RSS_SFR_IE 8'ha8
`define RSS_SFR_SLAVE_ADDRESS 8'ha9
`define RSS_SFR_P3 8'hb0
`define RSS_SFR_IPH 8'hb7
`define RSS_SFR_IP 8'hb8
`define RSS_SFR_SLAVE_ADDR_MASK 8'hb9
`define RSS_SFR_PSW 8'hd0
`define RSS_SFR_ACC 8'he0
`define RSS_SFR_B 8'hf0

// Reset values and writable masks
`define RSS_RV_ZERO 8'h00
`define RSS_RV_SP 8'h07
`define RSS_RV_PORT 8'hff
`define RSS_WM_FULL 8'hff
`define RSS_WM_POWER_CONTROL 8'hef
`define RSS_WM_CLK 8'h02
`define RSS_WM_COMPARATOR_CTRL_STATUS 8'h1f
`define RSS_WM_IE 8'hdf
`define RSS_WM_IP 8'h5f
`define RSS_POF_BIT 4
`define RSS_X2_BIT 0
`define RSS_RESET_VECTOR 16'h0000

`endif

/* common/rss_pkg.sv */
// Types shared by the reset source sequencer
package rss_pkg;
    typedef enum logic [1:0] {
        ST_COLD,
        ST_DIP,
        ST_DELAY,
        ST_RUN
    } rss_state_t;
endpackage

/* common/rss_sfr_if.sv */
// Access path between the sequencer core and its special register bank
interface rss_sfr_if;
    logic wr;
    logic [6:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] p1_q;
    logic [7:0] p3_q;
    modport core (output wr, idx, wdata, input rdata, p1_q, p3_q);
    modport bank (input wr, idx, wdata, output rdata, p1_q, p3_q);
endinterface

/* hdl/rss_rst_sync.sv */
// Asynchronous-assert, synchronous-release reset synchroniser
module rss_rst_sync (
    // Clock and combined reset request
    input wire logic pclk,
    input wire logic ce,
    input wire logic rst_n_in,
    // Released reset
    output logic rst_n_out
);
    logic meta_r;

    always_ff @(posedge pclk or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= 1'b0;
            rst_n_out <= 1'b0;
        end else if (ce) begin
            meta_r <= 1'b1;
            rst_n_out <= meta_r;
        end
    end
endmodule // rss_rst_sync

/* hdl/rss_sfr_bank.sv */
// Special register bank held at its initial values while reset is active
`include "rss_params.svh"
module rss_sfr_bank (
    // Clock, enable and internal reset
    input wire logic pclk,
    input wire logic ce,
    input wire logic sys_rst_n,
    // Access path
    rss_sfr_if.bank sfr
);
    logic [7:0] mem [0:127];

    function automatic logic [7:0] rst_val(input logic [7:0] a);
        case (a)
            `RSS_SFR_SP: rst_val = `RSS_RV_SP;
            `RSS_SFR_P1, `RSS_SFR_P3: rst_val = `RSS_RV_PORT;
            default: rst_val = `RSS_RV_ZERO;
        endcase
    endfunction

    // Zero mask marks an unimplemented address
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            `RSS_SFR_SP, `RSS_SFR_DPL, `RSS_SFR_DPH, `RSS_SFR_TIMER_CONTROL,
            `RSS_SFR_TIMER_MODES, `RSS_SFR_TL0, `RSS_SFR_TL1, `RSS_SFR_TH0,
            `RSS_SFR_TH1, `RSS_SFR_P1, `RSS_SFR_SERIAL_CONTROL, `RSS_SFR_SERIAL_BUFFER,
            `RSS_SFR_SLAVE_ADDRESS, `RSS_SFR_P3, `RSS_SFR_SLAVE_ADDR_MASK, `RSS_SFR_PSW,
            `RSS_SFR_ACC, `RSS_SFR_B: wmask = `RSS_WM_FULL;
            `RSS_SFR_POWER_CONTROL: wmask = `RSS_WM_POWER_CONTROL;
            `RSS_SFR_CLK: wmask = `RSS_WM_CLK;
            `RSS_SFR_COMPARATOR_CTRL_STATUS: wmask = `RSS_WM_COMPARATOR_CTRL_STATUS;
            `RSS_SFR_IE: wmask = `RSS_WM_IE;
            `RSS_SFR_IP, `RSS_SFR_IPH: wmask = `RSS_WM_IP;
            default: wmask = `RSS_RV_ZERO;
        endcase
    endfunction

    always_ff @(posedge pclk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            for (int i = 0; i < 128; i++) begin
                mem[i] <= rst_val(8'(i + 128)) & wmask(8'(i + 128));
            end
        end else if (ce && sfr.wr) begin
            // Writes to unimplemented addresses have no effect
            mem[sfr.idx] <= sfr.wdata & wmask({1'b1, sfr.idx});
        end
    end

    assign sfr.rdata = mem[sfr.idx] & wmask({1'b1, sfr.idx});
    assign sfr.p1_q = mem[7'(`RSS_SFR_P1)];
    assign sfr.p3_q = mem[7'(`RSS_SFR_P3)];
endmodule // rss_sfr_bank

/* hdl/rss_top.sv */
// Reset source sequencer with special register bank behind an APB slave
`include "rss_params.svh"
module rss_top
    import rss_pkg::*;
#(
    parameter int DELAY_CYCLES = `RSS_DELAY_NS / `RSS_CLK_PERIOD_NS
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supply monitors, reset pin, fuses
    input wire logic por_low,
    input wire logic supply_dip_detect,
    input wire logic ext_rst_pin,
    input wire logic xtal_bypass_fuse,
    input wire logic isp_fuse,
    input wire logic x2_fuse,
    // Programming requests
    input wire logic prog_wr_req,
    input wire logic prog_rd_req,
    output logic prog_wr_grant,
    output logic prog_rd_grant,
    // Core side
    output logic sys_rst_n,
    output logic fetch_start,
    output logic [15:0] fetch_addr,
    output logic osc_en,
    output logic in_system_programming,
    output logic clock_doubler_bit,
    output logic [7:0] p1_oe,
    output logic [7:0] p3_oe,
    output logic irq
);
    localparam int CW = $clog2(DELAY_CYCLES + 1);

    rss_sfr_if sfr ();

    rss_state_t state_r, state_nxt;
    logic [CW-1:0] cnt_r;
    logic rst_req_n;
    logic sys_rst_d_r;
    logic power_loss_flag_r;
    logic x2_r;
    logic x2_loaded_r;
    logic lock_bit_one_r;
    logic lock_bit_two_r;
    logic [`RSS_EV_W-1:0] status_r, mask_r, ev;
    logic pin_d_r;
    logic [9:0] idx;
    logic setup, access, wr_acc, rd_acc;
    logic is_sfr, is_own;
    logic [7:0] sfr_rd;
    logic [31:0] rd_mux;
    logic prog_ok, verify_ok;

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        if (por_low) begin
            state_nxt = ST_COLD;
        end else if (supply_dip_detect) begin
            state_nxt = ST_DIP;
        end else begin
            case (state_r)
                ST_COLD, ST_DIP: state_nxt = ST_DELAY;
                ST_DELAY: begin
                    if (cnt_r == CW'(DELAY_CYCLES - 1)) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: state_nxt = ST_RUN;
                default: state_nxt = ST_COLD;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_COLD;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // Count restarts whenever the delay state is left or re-entered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (ce) begin
            if (state_r == ST_DELAY && state_nxt == ST_DELAY) begin
                cnt_r <= cnt_r + CW'(1);
            end else begin
                cnt_r <= '0;
            end
        end
    end

    // Detector levels act directly on the reset net, no clock needed
    assign rst_req_n = presetn & ~por_low & ~supply_dip_detect
        & ~ext_rst_pin & (state_r == ST_RUN);

    rss_rst_sync u_rst_sync (
        .pclk(pclk),
        .ce(ce),
        .rst_n_in(rst_req_n),
        .rst_n_out(sys_rst_n)
    );

    rss_sfr_bank u_bank (
        .pclk(pclk),
        .ce(ce),
        .sys_rst_n(sys_rst_n),
        .sfr(sfr)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_rst_d_r <= 1'b0;
            fetch_start <= 1'b0;
            fetch_addr <= `RSS_RESET_VECTOR;
        end else if (ce) begin
            sys_rst_d_r <= sys_rst_n;
            fetch_start <= sys_rst_n & ~sys_rst_d_r;
            fetch_addr <= `RSS_RESET_VECTOR;
        end
    end

    // Drive low only where the latch holds a zero, none from the first enabled clock edge in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p1_oe <= '0;
            p3_oe <= '0;
        end else if (ce) begin
            p1_oe <= sys_rst_n ? ~sfr.p1_q : 8'h00;
            p3_oe <= sys_rst_n ? ~sfr.p3_q : 8'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_en <= 1'b0;
            in_system_programming <= 1'b0;
        end else if (ce) begin
            osc_en <= ~por_low & ~xtal_bypass_fuse;
            in_system_programming <= ext_rst_pin & isp_fuse;
        end
    end

    // APB decode; one access phase, no wait states while enabled
    assign idx = paddr[11:2];
    assign setup = psel & ~penable;
    assign access = psel & penable & ce;
    assign wr_acc = access & pwrite;
    assign rd_acc = access & ~pwrite;
    assign is_sfr = idx >= `RSS_IDX_SFR_BASE && idx <= `RSS_IDX_SFR_END;
    assign is_own = idx == `RSS_IDX_STATUS || idx == `RSS_IDX_MASK
        || idx == `RSS_IDX_STATE || idx == `RSS_IDX_LOCK;
    assign pready = ce;
    assign pslverr = psel & penable & ~is_sfr & ~is_own;

    // Held in reset the bank refuses writes, so they are dropped here
    assign sfr.wr = wr_acc & is_sfr & sys_rst_n;
    assign sfr.idx = idx[6:0];
    assign sfr.wdata = pwdata[7:0];

    always_comb begin
        sfr_rd = sfr.rdata;
        if (idx[7:0] == `RSS_SFR_POWER_CONTROL) begin
            sfr_rd[`RSS_POF_BIT] = power_loss_flag_r;
        end
        if (idx[7:0] == `RSS_SFR_CLK) begin
            sfr_rd[`RSS_X2_BIT] = x2_r;
        end
    end

    always_comb begin
        rd_mux = '0;
        if (is_sfr) begin
            rd_mux[7:0] = sfr_rd;
        end else begin
            case (idx)
                `RSS_IDX_STATUS: rd_mux[`RSS_EV_W-1:0] = status_r;
                `RSS_IDX_MASK: rd_mux[`RSS_EV_W-1:0] = mask_r;
                `RSS_IDX_STATE: rd_mux[7:0] = {lock_bit_two_r,
                    lock_bit_one_r, in_system_programming, osc_en,
                    ~sys_rst_n, 1'b0, state_r};
                `RSS_IDX_LOCK: rd_mux[7:0] = {6'h00, lock_bit_two_r,
                    lock_bit_one_r};
                default: rd_mux = '0;
            endcase
        end
    end

    // Read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (ce && setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Power loss flag survives every reset but a cold one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_loss_flag_r <= 1'b1;
        end else if (ce) begin
            if (por_low) begin
                power_loss_flag_r <= 1'b1;
            end else if (sfr.wr && idx[7:0] == `RSS_SFR_POWER_CONTROL) begin
                power_loss_flag_r <= pwdata[`RSS_POF_BIT];
            end
        end
    end

    // Doubler loads from its fuse at power-up only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x2_r <= 1'b0;
            x2_loaded_r <= 1'b0;
        end else if (ce) begin
            if (por_low || !x2_loaded_r) begin
                x2_r <= x2_fuse;
                x2_loaded_r <= 1'b1;
            end else if (sfr.wr && idx[7:0] == `RSS_SFR_CLK) begin
                x2_r <= pwdata[`RSS_X2_BIT];
            end
        end
    end
    assign clock_doubler_bit = x2_r;

    // Lock bits: commands only program them; erase alone clears both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_bit_one_r <= 1'b0;
            lock_bit_two_r <= 1'b0;
        end else if (ce && wr_acc && idx == `RSS_IDX_LOCK
                     && in_system_programming) begin
            if (pwdata[`RSS_LOCK_ERASE]) begin
                lock_bit_one_r <= 1'b0;
                lock_bit_two_r <= 1'b0;
            end else begin
                lock_bit_one_r <= lock_bit_one_r | pwdata[`RSS_LOCK_B1];
                lock_bit_two_r <= lock_bit_two_r | pwdata[`RSS_LOCK_B2];
            end
        end
    end

    assign prog_ok = in_system_programming & ~lock_bit_one_r;
    assign verify_ok = in_system_programming
        & ~(lock_bit_one_r & lock_bit_two_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_wr_grant <= 1'b0;
            prog_rd_grant <= 1'b0;
        end else if (ce) begin
            prog_wr_grant <= prog_wr_req & prog_ok;
            prog_rd_grant <= prog_rd_req & verify_ok;
        end
    end

    // Events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_d_r <= 1'b0;
        end else if (ce) begin
            pin_d_r <= ext_rst_pin;
        end
    end

    always_comb begin
        ev = '0;
        ev[`RSS_EV_COLD] = por_low && state_r != ST_COLD;
        ev[`RSS_EV_DIP] = supply_dip_detect && !por_low && state_r != ST_DIP;
        ev[`RSS_EV_PIN] = ext_rst_pin & ~pin_d_r;
        ev[`RSS_EV_REJECT] = (prog_wr_req & ~prog_ok)
            | (prog_rd_req & ~verify_ok);
        ev[`RSS_EV_RUN] = state_r == ST_DELAY && state_nxt == ST_RUN;
    end

    // A read clears the status, but an event in that cycle still lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= '0;
        end else if (ce) begin
            if (rd_acc && idx == `RSS_IDX_STATUS) begin
                status_r <= ev;
            end else begin
                status_r <= status_r | ev;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= '0;
        end else if (ce && wr_acc && idx == `RSS_IDX_MASK) begin
            mask_r <= pwdata[`RSS_EV_W-1:0];
        end
    end

    assign irq = |(status_r & mask_r);
endmodule // rss_top

/* test/rss_top_monitor.sv */
// Port checker for the reset source sequencer
module rss_top_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Sources, fuses and requests
    input wire logic por_low,
    input wire logic supply_dip_detect,
    input wire logic ext_rst_pin,
    input wire logic xtal_bypass_fuse,
    input wire logic isp_fuse,
    input wire logic prog_wr_req,
    input wire logic prog_rd_req,
    // Observed outputs
    input wire logic prog_wr_grant,
    input wire logic prog_rd_grant,
    input wire logic sys_rst_n,
    input wire logic fetch_start,
    input wire logic [15:0] fetch_addr,
    input wire logic osc_en,
    input wire logic in_system_programming,
    input wire logic [7:0] p1_oe,
    input wire logic [7:0] p3_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic src;
    assign src = por_low | supply_dip_detect | ext_rst_pin;
    a_any_source: assert property (src |-> !sys_rst_n)
        else $error("internal reset free while a source is active");
    // Eight cycles is well below any delay setting used
    a_por_delay: assert property ($fell(por_low) |->
        (!sys_rst_n) [*8]) else $error("early release after power-on");
    a_dip_delay: assert property ($fell(supply_dip_detect) |->
        (!sys_rst_n) [*8]) else $error("early release after supply dip");
    a_sync_release: assert property ($rose(sys_rst_n) |->
        !src && !$past(src)) else $error("release not clock aligned");
    a_fetch_vector: assert property ($rose(sys_rst_n) |=>
        fetch_start && fetch_addr == 16'h0000 ##1 !fetch_start)
        else $error("fetch start pulse or vector wrong");
    a_ports_weak: assert property ((!sys_rst_n) [*2] |->
        p1_oe == 8'h00 && p3_oe == 8'h00)
        else $error("port driven during reset");
    a_isp_entry: assert property (ext_rst_pin && isp_fuse |=>
        in_system_programming) else $error("programming mode missed");
    a_osc_follow: assert property (ce |=>
        osc_en == $past(!por_low && !xtal_bypass_fuse))
        else $error("oscillator enable wrong");
    a_wr_grant: assert property (prog_wr_grant |->
        $past(prog_wr_req && in_system_programming))
        else $error("write grant without cause");
    a_rd_grant: assert property (prog_rd_grant |->
        $past(prog_rd_req && in_system_programming))
        else $error("verify grant without cause");
    a_ce_freeze: assert property (!ce |=> $stable(p1_oe)
        && $stable(osc_en) && $stable(prog_wr_grant))
        else $error("state moved while enable low");
    c_boot: cover property ($rose(sys_rst_n));
    c_wr_grant: cover property (prog_wr_grant);
    c_irq: cover property ($rose(irq));
    c_stall: cover property (!ce ##1 ce);
endmodule // rss_top_monitor

bind rss_top rss_top_monitor i_mon (
    .pclk(pclk), .presetn(presetn), .ce(ce), .por_low(por_low),
    .supply_dip_detect(supply_dip_detect), .ext_rst_pin(ext_rst_pin),
    .xtal_bypass_fuse(xtal_bypass_fuse), .isp_fuse(isp_fuse),
    .prog_wr_req(prog_wr_req), .prog_rd_req(prog_rd_req),
    .prog_wr_grant(prog_wr_grant), .prog_rd_grant(prog_rd_grant),
    .sys_rst_n(sys_rst_n), .fetch_start(fetch_start),
    .fetch_addr(fetch_addr), .osc_en(osc_en),
    .in_system_programming(in_system_programming),
    .p1_oe(p1_oe), .p3_oe(p3_oe), .irq(irq)
);

/* test/rss_supply_model.sv */
// Supply monitors and external reset pin driver
module rss_supply_model (
    // Clock
    input wire logic pclk,
    // Indications towards the sequencer
    output logic por_low,
    output logic supply_dip_detect,
    output logic ext_rst_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Slower machine cycle assumed, so the hold is safe at both rates
    parameter int MACH_CYC = 12;
    initial begin
        por_low = 1'b1;
        supply_dip_detect = 1'b0;
        ext_rst_pin = 1'b0;
    end
    task automatic supply_up();
        @(posedge pclk);
        por_low <= 1'b0;
    endtask
    task automatic supply_down();
        @(posedge pclk);
        por_low <= 1'b1;
    endtask
    task automatic dip(input logic on);
        @(posedge pclk);
        supply_dip_detect <= on;
    endtask
    task automatic pin(input logic on);
        @(posedge pclk);
        ext_rst_pin <= on;
        if (on) begin
            repeat (2 * MACH_CYC) @(posedge pclk);
        end
    endtask
endmodule // rss_supply_model

/* test/rss_top_tb.sv */
// Self-checking bench for the reset source sequencer
module rss_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 20;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } rss_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic por_low, supply_dip_detect, ext_rst_pin, isp_fuse, ce;
    logic prog_wr_req, prog_rd_req, prog_wr_grant, prog_rd_grant;
    logic sys_rst_n, fetch_start, osc_en, in_system_programming;
    logic clock_doubler_bit, ev, xtal_bypass_fuse, x2_fuse;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [15:0] fetch_addr;
    logic [7:0] p1_oe, p3_oe;
    int bad_count, checks_done, cnt;
    // Rows write implemented addresses only
    rss_row_t rows [12] = '{
        '{1'b0, 12'h204, 8'h00, 8'h07}, '{1'b0, 12'h208, 8'h00, 8'h00},
        '{1'b0, 12'h20c, 8'h00, 8'h00}, '{1'b0, 12'h21c, 8'h00, 8'h10},
        '{1'b0, 12'h224, 8'h00, 8'h00}, '{1'b0, 12'h240, 8'h00, 8'hff},
        '{1'b0, 12'h260, 8'h00, 8'h00}, '{1'b0, 12'h2c0, 8'h00, 8'hff},
        '{1'b0, 12'h340, 8'h00, 8'h00}, '{1'b0, 12'h3c0, 8'h00, 8'h00},
        '{1'b1, 12'h204, 8'h55, 8'h00}, '{1'b0, 12'h204, 8'h00, 8'h55}};
    // Lock command and expected {lock bits, write grant, verify grant}
    logic [7:0] lk_d [4] = '{8'h01, 8'h02, 8'h00, 8'h80};
    logic [3:0] lk_e [4] = '{4'b0101, 4'b1100, 4'b1100, 4'b0011};

    rss_supply_model i_sup (.pclk(pclk), .por_low(por_low),
        .supply_dip_detect(supply_dip_detect), .ext_rst_pin(ext_rst_pin));
    rss_top #(.DELAY_CYCLES(DLY)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .por_low(por_low),
        .supply_dip_detect(supply_dip_detect), .ext_rst_pin(ext_rst_pin),
        .xtal_bypass_fuse(xtal_bypass_fuse), .isp_fuse(isp_fuse),
        .x2_fuse(x2_fuse), .prog_wr_req(prog_wr_req),
        .prog_rd_req(prog_rd_req),
        .prog_wr_grant(prog_wr_grant), .prog_rd_grant(prog_rd_grant),
        .sys_rst_n(sys_rst_n), .fetch_start(fetch_start),
        .fetch_addr(fetch_addr), .osc_en(osc_en),
        .in_system_programming(in_system_programming),
        .clock_doubler_bit(clock_doubler_bit), .p1_oe(p1_oe),
        .p3_oe(p3_oe), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data and error land in rv and ev
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready ends the wait for the answer; only the watchdog ends one that never comes
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic waitrel();
        cnt = 0;
        while (sys_rst_n !== 1'b1 && cnt < 1000) begin
            @(posedge pclk);
            #1;
            cnt++;
        end
        chk(sys_rst_n, 1);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {isp_fuse, prog_wr_req, prog_rd_req, xtal_bypass_fuse} = '0;
        {ce, x2_fuse} = 2'b11;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        tick(2);
        chk(sys_rst_n, 0);
        chk(osc_en, 0);
        chk(p1_oe, 0);
        i_sup.supply_up();
        waitrel();
        chk(cnt >= DLY && cnt <= DLY + 5, 1);
        chk(osc_en, 1);
        chk(clock_doubler_bit, 1);
        $display("power-up test done");
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, {24'h0, rows[i].d});
            if (!rows[i].w) chk(rv, {24'h0, rows[i].e});
        end
        $display("register table test done");
        apb(1'b1, 12'h21c, 32'h0);
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b0, 12'h004, 32'h0);
        apb(1'b1, 12'h240, 32'h0f);
        tick(2);
        chk(p1_oe, 8'hf0);
        chk(irq, 0);
        // Enable low stalls the write and freezes the port drive
        @(posedge pclk);
        ce <= 1'b0;
        fork
            apb(1'b1, 12'h240, 32'h3c);
            begin
                tick(4);
                chk(pready, 0);
                chk(p1_oe, 8'hf0);
                @(posedge pclk);
                ce <= 1'b1;
            end
        join
        tick(2);
        chk(p1_oe, 8'hc3);
        $display("clock enable test done");
        i_sup.dip(1'b1);
        #1;
        chk(sys_rst_n, 0);
        tick(2);
        chk(p1_oe, 0);
        chk(p3_oe, 0);
        chk(irq, 1);
        i_sup.dip(1'b0);
        waitrel();
        chk(cnt >= DLY && cnt <= DLY + 5, 1);
        apb(1'b0, 12'h21c, 32'h0);
        chk(rv, 0);
        apb(1'b0, 12'h240, 32'h0);
        chk(rv, 32'hff);
        apb(1'b0, 12'h004, 32'h0);
        chk(rv[1], 1);
        tick(1);
        chk(irq, 0);
        $display("supply dip test done");
        @(posedge pclk);
        isp_fuse <= 1'b1;
        prog_wr_req <= 1'b1;
        prog_rd_req <= 1'b1;
        i_sup.pin(1'b1);
        #1;
        chk(sys_rst_n, 0);
        chk(in_system_programming, 1);
        chk({prog_wr_grant, prog_rd_grant}, 2'b11);
        foreach (lk_d[i]) begin
            apb(1'b1, 12'h010, {24'h0, lk_d[i]});
            tick(2);
            chk({prog_wr_grant, prog_rd_grant}, lk_e[i][1:0]);
            apb(1'b0, 12'h010, 32'h0);
            chk(rv, {30'h0, lk_e[i][3:2]});
        end
        apb(1'b0, 12'h00c, 32'h0);
        chk(rv[5], 1);
        i_sup.pin(1'b0);
        waitrel();
        chk(cnt <= 5, 1);
        $display("pin and lock test done");
        apb(1'b0, 12'h020, 32'h0);
        chk(ev, 1);
        chk(rv, 0);
        $display("unmapped access test done");
        @(posedge pclk);
        xtal_bypass_fuse <= 1'b1;
        x2_fuse <= 1'b0;
        tick(2);
        chk(osc_en, 0);
        chk(clock_doubler_bit, 1);
        apb(1'b1, 12'h23c, 32'h0);
        tick(1);
        chk(clock_doubler_bit, 0);
        $display("fuse test done");
        @(posedge pclk);
        x2_fuse <= 1'b1;
        i_sup.supply_down();
        tick(2);
        chk(sys_rst_n, 0);
        chk(clock_doubler_bit, 1);
        apb(1'b0, 12'h21c, 32'h0);
        chk(rv, 32'h10);
        $display("cold reset test done");
        report_and_stop();
    end
endmodule // rss_top_tb
